// [hw/scac_pkg.sv]
package scac_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] SCAC_ADDR_ALTCTL = 8'h08;
  localparam logic [7:0] SCAC_ADDR_EGT = 8'h0c;
  localparam logic [7:0] SCAC_ADDR_RTO = 8'h10;
  localparam logic [7:0] SCAC_ADDR_ETU = 8'h14;
  localparam logic [7:0] SCAC_ADDR_CTRL = 8'h40;
  localparam logic [7:0] SCAC_ADDR_STAT = 8'h44;
  // ==========================================================================
  // Alternate control field positions
  localparam int SCAC_B_TXRST = 0;
  localparam int SCAC_B_RXRST = 1;
  localparam int SCAC_B_DACT = 2;
  localparam int SCAC_B_ACT = 3;
  localparam int SCAC_B_WARM = 4;
  localparam int SCAC_B_T0SEN = 5;
  localparam int SCAC_B_INITSEL = 8;
  localparam int SCAC_B_BGT = 12;
  localparam int SCAC_B_T0ATV = 13;
  localparam int SCAC_B_DATA_PIN_DRIVE_SELECT = 16;
  // Own control register bit positions.
  localparam int SCAC_B_CEN = 0;
  localparam int SCAC_B_TSEL = 1;
  localparam int SCAC_B_AR0 = 3;
  localparam int SCAC_B_RTOIE = 6;
  // Own status register bit positions.
  localparam int SCAC_B_INITIS = 0;
  localparam int SCAC_B_RTOIS = 1;
  // ==========================================================================
  // Reset values and timing
  localparam logic [11:0] SCAC_ETU_RESET = 12'h173;
  localparam int SCAC_STEP_BASE = 42;
  localparam int SCAC_T0_LEN = 16;
  localparam int SCAC_T8_LEN = 8;
  typedef enum logic [4:0] {
    SCAC_IDLE = 5'h01,
    SCAC_STEP1 = 5'h02,
    SCAC_STEP2 = 5'h04,
    SCAC_STEP3 = 5'h08,
    SCAC_DONE = 5'h10
  } scac_seq_type;
endpackage

// [hw/scac_alt_control.sv]
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// What this block does
// RULE_01: Data pin output mode bit picks quasi-bidirectional (0) or open-drain (1) drive.
// RULE_02: Read-only bits show whether timers 2, 1 and 0 are counting.
// RULE_03: Receiver guard enable bit turns block guard checking off or on.
// RULE_04: Two-bit initial timing field sets sequence step spacing in card clocks.
// RULE_05: Timer start bit 0 stops, 1 reloads and starts the timer.
// RULE_06: Software avoids timer1 start with select 00/01, timer2 unless select 11.
// RULE_07: Without auto-reload, hardware clears the timer start bit when it expires.
// RULE_08: Either software reset clears timer starts and the three sequence triggers.
// RULE_09: With engine disabled, writes to starts and triggers are ignored.
// RULE_10: Warm reset trigger runs warm reset, then self-clears and sets done flag.
// RULE_11: Activation trigger runs activation, then self-clears and sets done flag.
// RULE_12: Deactivation trigger runs deactivation, then self-clears and sets done flag.
// RULE_13: Receive reset flushes receive side and clears itself when finished.
// RULE_14: Transmit reset flushes transmit side and clears itself when finished.
// RULE_15: Eight-bit extended guard field adds exactly that many ETUs between characters.
// RULE_16: Nine-bit receive time-out reloads on new data; reaching 1 raises time-out.
// RULE_17: Time-out interval equals programmed ETUs plus half an ELEMENTARY_TIME_UNIT.
// RULE_18: A zero receive time-out field disables the function.
// RULE_19: Compensation mode alternates ETUs of n and n-1 clocks.
// RULE_20: ELEMENTARY_TIME_UNIT lasts divider plus one clocks; divider resets to 0x173.
// RULE_21: Software always programs the divider above 0x004.
// RULE_22: Clearing engine enable forces every state machine back to idle.
// RULE_23: Done flag reads only, clears on writing 1; software clears after completion.
// RULE_24: Sequences drive reset, clock, data, power pins in fixed order with timed steps. The code sequences only reset, clock and power, not data.
module scac_alt_control
  import scac_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_word_strobe,
  input wire logic rx_buffer_read,
  output logic rx_timeout_irq,
  output logic rx_flush,
  output logic tx_flush,
  output logic rx_guard_check_enable,
  output logic [7:0] extra_guard_etus,
  output logic etu_tick,
  output logic half_etu_tick,
  output logic [2:0] timer_expired,
  output logic card_rst_out,
  output logic card_clk_en,
  output logic card_pwr_en,
  output logic card_data_pin_out,
  output logic card_data_pin_oe_n,
  input wire logic card_data_pin_in
);

  // ==========================================================================
  // Register state
  logic [31:0] alt_r;
  logic [7:0] egt_r;
  logic [8:0] rto_r;
  logic etu_comp_r;
  logic [11:0] etu_div_r;
  logic [6:0] ctrl_r;
  logic init_done_flag_r;
  logic rto_flag_r;
  logic data_meta_r;
  logic data_sync_r;
  logic data_last_r;

  // Bus decode.
  wire access_w = psel && penable;
  wire wr_w = access_w && pwrite;
  wire wr_alt = wr_w && (paddr == SCAC_ADDR_ALTCTL);
  wire wr_egt = wr_w && (paddr == SCAC_ADDR_EGT);
  wire wr_rto = wr_w && (paddr == SCAC_ADDR_RTO);
  wire wr_etu = wr_w && (paddr == SCAC_ADDR_ETU);
  wire wr_ctrl = wr_w && (paddr == SCAC_ADDR_CTRL);
  wire wr_stat = wr_w && (paddr == SCAC_ADDR_STAT);
  wire addr_ok = (paddr == SCAC_ADDR_ALTCTL) || (paddr == SCAC_ADDR_EGT) || (paddr == SCAC_ADDR_RTO) ||
                 (paddr == SCAC_ADDR_ETU) || (paddr == SCAC_ADDR_CTRL) || (paddr == SCAC_ADDR_STAT);
  wire engine_enable = ctrl_r[SCAC_B_CEN];
  wire [1:0] timer_config_select = ctrl_r[SCAC_B_TSEL+1:SCAC_B_TSEL];
  wire [2:0] timer_autoreload = ctrl_r[SCAC_B_AR0+2:SCAC_B_AR0];
  wire rx_timeout_irq_enable = ctrl_r[SCAC_B_RTOIE];
  // RULE_08 software resets
  wire sw_reset = alt_r[SCAC_B_TXRST] | alt_r[SCAC_B_RXRST];
  // RULE_09 gated writes
  wire gated_wr = wr_alt && engine_enable;

  // ==========================================================================
  // ELEMENTARY_TIME_UNIT generator
  logic [11:0] etu_cnt_r;
  logic comp_phase_r;
  // RULE_19 compensation alternation
  wire [11:0] etu_end = (etu_comp_r && comp_phase_r) ? etu_div_r - 12'h001 : etu_div_r;
  // RULE_20 divider plus one
  wire etu_wrap = (etu_cnt_r >= etu_end);
  wire etu_half = (etu_cnt_r == {1'b0, etu_end[11:1]});

  // Counts core clocks; a count from 0 to etu_end spans etu_end+1 clocks.
  always_ff @(posedge core_clk) begin
    if (rst || !engine_enable) begin
      etu_cnt_r <= 12'h000;
      comp_phase_r <= 1'b0;
      etu_tick <= 1'b0;
      half_etu_tick <= 1'b0;
    end else begin
      etu_cnt_r <= etu_wrap ? 12'h000 : etu_cnt_r + 12'h001;
      comp_phase_r <= etu_wrap ? ~comp_phase_r : comp_phase_r;
      etu_tick <= etu_wrap;
      half_etu_tick <= etu_half;
    end
  end

  // ==========================================================================
  // Internal timers
  logic [2:0] tmr_act_r;
  logic [7:0] tmr_cnt_r [3];
  logic [2:0] tmr_exp;
  wire [2:0] tmr_allowed = {timer_config_select == 2'b11, timer_config_select[1], timer_config_select != 2'b00};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_tmr
      localparam logic [7:0] LEN = (i == 0) ? 8'(SCAC_T0_LEN) : 8'(SCAC_T8_LEN);
      wire start_w = gated_wr && pwdata[SCAC_B_T0SEN+i] && !alt_r[SCAC_B_T0SEN+i];
      assign tmr_exp[i] = tmr_act_r[i] && etu_tick && (tmr_cnt_r[i] == 8'h01);
      // Timer counts ETUs down from its length, reloading on start.
      always_ff @(posedge core_clk) begin
        if (rst || !engine_enable || sw_reset || !tmr_allowed[i]) begin
          tmr_act_r[i] <= 1'b0;
          tmr_cnt_r[i] <= 8'h00;
        // RULE_05 reload and start
        end else if (start_w) begin
          tmr_act_r[i] <= 1'b1;
          tmr_cnt_r[i] <= LEN;
        end else if (gated_wr && !pwdata[SCAC_B_T0SEN+i]) begin
          tmr_act_r[i] <= 1'b0;
        end else if (tmr_exp[i]) begin
          tmr_cnt_r[i] <= LEN;
          tmr_act_r[i] <= timer_autoreload[i];
        end else if (tmr_act_r[i] && etu_tick) begin
          tmr_cnt_r[i] <= tmr_cnt_r[i] - 8'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_expired <= 3'b000;
    end else begin
      timer_expired <= tmr_exp;
    end
  end

  // ==========================================================================
  // Sequence generator
  scac_seq_type seq_r;
  scac_seq_type seq_nxt;
  logic [9:0] step_cnt_r;
  // RULE_04 step spacing
  wire [9:0] step_len = 10'(SCAC_STEP_BASE) << alt_r[SCAC_B_INITSEL+1:SCAC_B_INITSEL];
  wire step_end = (step_cnt_r >= step_len);
  wire [2:0] seq_req = alt_r[SCAC_B_WARM:SCAC_B_DACT];
  wire seq_done = (seq_r == SCAC_DONE);

  // Advances one step each time the spacing counter runs out.
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      SCAC_IDLE: begin
        if (seq_req != 3'b000) begin
          seq_nxt = SCAC_STEP1;
        end
      end
      SCAC_STEP1: begin
        if (step_end) begin
          seq_nxt = SCAC_STEP2;
        end
      end
      SCAC_STEP2: begin
        if (step_end) begin
          seq_nxt = SCAC_STEP3;
        end
      end
      SCAC_STEP3: begin
        if (step_end) begin
          seq_nxt = SCAC_DONE;
        end
      end
      SCAC_DONE: begin
        seq_nxt = SCAC_IDLE;
      end
      default: begin
        seq_nxt = SCAC_IDLE;
      end
    endcase
  end

  // RULE_22 engine off idles
  always_ff @(posedge core_clk) begin
    if (rst || !engine_enable || sw_reset) begin
      seq_r <= SCAC_IDLE;
      step_cnt_r <= 10'h000;
    end else begin
      seq_r <= seq_nxt;
      step_cnt_r <= (seq_nxt != seq_r) ? 10'h000 : step_cnt_r + 10'h001;
    end
  end

  // RULE_24 pin order per sequence
  always_ff @(posedge core_clk) begin
    if (rst) begin
      card_pwr_en <= 1'b0;
      card_clk_en <= 1'b0;
      card_rst_out <= 1'b0;
    end else if (!engine_enable) begin
      card_clk_en <= 1'b0;
      card_rst_out <= 1'b0;
    end else if (seq_r == SCAC_STEP1) begin
      card_pwr_en <= seq_req[1] ? 1'b1 : card_pwr_en;
      card_rst_out <= 1'b0;
    end else if (seq_r == SCAC_STEP2) begin
      card_clk_en <= !seq_req[0];
    end else if (seq_r == SCAC_STEP3) begin
      card_rst_out <= !seq_req[0];
      card_pwr_en <= seq_req[0] ? 1'b0 : card_pwr_en;
    end
  end

  // ==========================================================================
  // Receive time-out
  logic [8:0] rto_cnt_r;
  logic rto_half_r;
  // RULE_18 zero disables
  wire rto_on = engine_enable && (rto_r != 9'h000);

  // RULE_16 reload on data
  // RULE_17 extra half ELEMENTARY_TIME_UNIT
  always_ff @(posedge core_clk) begin
    if (rst || !rto_on || alt_r[SCAC_B_RXRST]) begin
      rto_cnt_r <= 9'h000;
      rto_half_r <= 1'b0;
    end else if (rx_word_strobe || rx_buffer_read) begin
      rto_cnt_r <= rto_r;
      rto_half_r <= 1'b1;
    end else if (rto_half_r && half_etu_tick) begin
      rto_half_r <= 1'b0;
    end else if (!rto_half_r && etu_tick && rto_cnt_r != 9'h000) begin
      rto_cnt_r <= rto_cnt_r - 9'h001;
    end
  end
  // Fires on the tick that takes the count from 1 to 0, so it cannot repeat, and never beside new data.
  wire rto_event = rto_on && !rto_half_r && etu_tick && (rto_cnt_r == 9'h001) &&
                   !rx_word_strobe && !rx_buffer_read;

  // ==========================================================================
  // Alternate control register
  logic [31:0] alt_nxt;
  wire [2:0] tmr_stop_hw = tmr_exp & ~timer_autoreload;

  // Software fields, self-clearing bits and hardware clears.
  always_comb begin
    alt_nxt = alt_r;
    if (wr_alt) begin
      alt_nxt[SCAC_B_DATA_PIN_DRIVE_SELECT] = pwdata[SCAC_B_DATA_PIN_DRIVE_SELECT];
      alt_nxt[SCAC_B_BGT] = pwdata[SCAC_B_BGT];
      alt_nxt[SCAC_B_INITSEL+1:SCAC_B_INITSEL] = pwdata[SCAC_B_INITSEL+1:SCAC_B_INITSEL];
      alt_nxt[SCAC_B_RXRST:SCAC_B_TXRST] = pwdata[SCAC_B_RXRST:SCAC_B_TXRST];
    end
    if (gated_wr) begin
      alt_nxt[SCAC_B_T0SEN+2:SCAC_B_DACT] = pwdata[SCAC_B_T0SEN+2:SCAC_B_DACT];
    end
    // RULE_07 one-shot clear
    alt_nxt[SCAC_B_T0SEN+2:SCAC_B_T0SEN] = alt_nxt[SCAC_B_T0SEN+2:SCAC_B_T0SEN] & ~tmr_stop_hw;
    // RULE_10 RULE_11 RULE_12 done clears
    if (seq_done) begin
      alt_nxt[SCAC_B_WARM:SCAC_B_DACT] = 3'b000;
    end
    // RULE_08 reset clears
    if (sw_reset || !engine_enable) begin
      alt_nxt[SCAC_B_T0SEN+2:SCAC_B_DACT] = 6'h00;
    end
    // RULE_13 RULE_14 self clear after one cycle
    if (alt_r[SCAC_B_RXRST]) begin
      alt_nxt[SCAC_B_RXRST] = 1'b0;
    end
    if (alt_r[SCAC_B_TXRST]) begin
      alt_nxt[SCAC_B_TXRST] = 1'b0;
    end
    // RULE_02 live timer status
    alt_nxt[SCAC_B_T0ATV+2:SCAC_B_T0ATV] = tmr_act_r;
    alt_nxt[31:SCAC_B_DATA_PIN_DRIVE_SELECT+1] = '0;
    alt_nxt[11:10] = 2'b00;
  end

  // Register writes.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alt_r <= 32'h0000_0000;
      egt_r <= 8'h00;
      rto_r <= 9'h000;
      etu_comp_r <= 1'b0;
      etu_div_r <= SCAC_ETU_RESET;
      ctrl_r <= 7'h00;
    end else begin
      alt_r <= alt_nxt;
      egt_r <= wr_egt ? pwdata[7:0] : egt_r;
      rto_r <= wr_rto ? pwdata[8:0] : rto_r;
      etu_comp_r <= wr_etu ? pwdata[15] : etu_comp_r;
      etu_div_r <= wr_etu ? pwdata[11:0] : etu_div_r;
      ctrl_r <= wr_ctrl ? pwdata[6:0] : ctrl_r;
    end
  end

  // RULE_23 write-one clear, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      init_done_flag_r <= 1'b0;
      rto_flag_r <= 1'b0;
    end else begin
      init_done_flag_r <= seq_done | (init_done_flag_r & ~(wr_stat & pwdata[SCAC_B_INITIS]));
      rto_flag_r <= rto_event | (rto_flag_r & ~(wr_stat & pwdata[SCAC_B_RTOIS]) & ~rx_buffer_read);
    end
  end

  // ==========================================================================
  // APB read path and registered outputs
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      SCAC_ADDR_ALTCTL: rd_mux = alt_r;
      SCAC_ADDR_EGT: rd_mux = {24'h000000, egt_r};
      SCAC_ADDR_RTO: rd_mux = {23'h000000, rto_r};
      SCAC_ADDR_ETU: rd_mux = {16'h0000, etu_comp_r, 3'b000, etu_div_r};
      SCAC_ADDR_CTRL: rd_mux = {25'h0000000, ctrl_r};
      SCAC_ADDR_STAT: rd_mux = {30'h00000000, rto_flag_r, init_done_flag_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero-wait answer: pready rises as the access phase starts, registered from the setup cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
    end
  end

  // Pin side and field outputs.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_meta_r <= 1'b1;
      data_sync_r <= 1'b1;
      data_last_r <= 1'b1;
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
      rx_guard_check_enable <= 1'b0;
      extra_guard_etus <= 8'h00;
      rx_timeout_irq <= 1'b0;
      card_data_pin_out <= 1'b1;
      card_data_pin_oe_n <= 1'b1;
    end else begin
      data_meta_r <= card_data_pin_in;
      data_sync_r <= data_meta_r;
      data_last_r <= data_sync_r;
      // RULE_13 RULE_14 flush pulses
      rx_flush <= alt_r[SCAC_B_RXRST];
      tx_flush <= alt_r[SCAC_B_TXRST];
      // RULE_03 guard check
      rx_guard_check_enable <= alt_r[SCAC_B_BGT];
      // RULE_15 exact guard
      extra_guard_etus <= egt_r;
      rx_timeout_irq <= rto_flag_r & rx_timeout_irq_enable;
      card_data_pin_out <= 1'b1;
      // RULE_01 quasi edge boost
      // Quasi mode drives the line high for one cycle after it rises; open-drain mode never drives.
      card_data_pin_oe_n <= alt_r[SCAC_B_DATA_PIN_DRIVE_SELECT] | !(data_sync_r & !data_last_r);
    end
  end

endmodule

// [test/scac_alt_control_chk.sv]
`timescale 1ns/1ps
// ============================================================
// Port checks for the alternate control block.
module scac_alt_control_chk
  import scac_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_flush,
  input wire logic tx_flush,
  input wire logic rx_guard_check_enable,
  input wire logic [7:0] extra_guard_etus,
  input wire logic etu_tick,
  input wire logic card_data_pin_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Write strobes for the two mapped registers watched here.
  wire logic alt_wr = psel & penable & pwrite & (paddr == SCAC_ADDR_ALTCTL);
  wire logic egt_wr = psel & penable & pwrite & (paddr == SCAC_ADDR_EGT);

  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_READ: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("bad error answer");
  AST_ETU_MAPPED: assert property (pready && paddr == SCAC_ADDR_ETU |-> !pslverr)
    else $error("mapped register refused");
  AST_GUARD: assert property (alt_wr |-> ##2 rx_guard_check_enable == $past(pwdata[SCAC_B_BGT], 2))
    else $error("guard enable not following write");
  AST_EGT: assert property (egt_wr |-> ##2 extra_guard_etus == $past(pwdata[7:0], 2))
    else $error("guard count not following write");
  AST_RX_FLUSH: assert property (alt_wr && pwdata[1] |-> ##[1:2] rx_flush)
    else $error("no receive flush");
  AST_TX_FLUSH: assert property (alt_wr && pwdata[0] |-> ##[1:2] tx_flush)
    else $error("no transmit flush");
  AST_FLUSH_PULSE: assert property (rx_flush |=> !rx_flush)
    else $error("receive flush too long");
  AST_PIN_OUT: assert property (card_data_pin_out)
    else $error("data pin output not high");
  AST_ETU_GAP: assert property (etu_tick |=> !etu_tick [*3])
    else $error("time unit ticks too close");
endmodule

bind scac_alt_control scac_alt_control_chk u_scac_alt_control_chk (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_flush, .tx_flush, .rx_guard_check_enable,
  .extra_guard_etus, .etu_tick, .card_data_pin_out);

// [test/scac_card_model.sv]
`timescale 1ns/1ps
// ============================================================
// Card end of the data line, which idles high through a pull-up.
module scac_card_model (
  input wire logic card_pwr_en,
  input wire logic card_data_pin_out,
  input wire logic card_data_pin_oe_n,
  input wire logic card_pull_low,
  output logic card_data_pin_in
);
  assign card_data_pin_in = !((!card_data_pin_oe_n && !card_data_pin_out) || (card_pwr_en && card_pull_low));
endmodule

// [test/smartcard_host_alt_control_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %h want %h", $time, g, e); end end
// ============================================================
// Register level bench for the alternate control block.
module smartcard_host_alt_control_test;
  import scac_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, rx_word_strobe, rx_buffer_read, card_pull_low, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, prdata;
  logic pready, pslverr, rx_timeout_irq, rx_flush, tx_flush, rx_guard_check_enable, etu_tick, half_etu_tick;
  logic card_rst_out, card_clk_en, card_pwr_en, card_data_pin_out, card_data_pin_oe_n, card_data_pin_in;
  logic [7:0] extra_guard_etus;
  logic [2:0] timer_expired;
  int fail_count = 0;
  int checks = 0;
  int gap_a, gap_b;
  logic [2:0] exp_seen;
  logic [7:0] adr [4] = '{SCAC_ADDR_ALTCTL, SCAC_ADDR_EGT, SCAC_ADDR_RTO, SCAC_ADDR_ETU};
  logic [31:0] rst_v [4] = '{32'h0, 32'h0, 32'h0, 32'h173};
  logic [31:0] wr_v [4] = '{32'h0, 32'ha5, 32'hffffffff, 32'hffffffff};
  logic [31:0] rb_v [4] = '{32'h0, 32'ha5, 32'h1ff, 32'h8fff};

  scac_alt_control u_scac_alt_control (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_word_strobe, .rx_buffer_read, .rx_timeout_irq, .rx_flush, .tx_flush,
    .rx_guard_check_enable, .extra_guard_etus, .etu_tick, .half_etu_tick, .timer_expired, .card_rst_out,
    .card_clk_en, .card_pwr_en, .card_data_pin_out, .card_data_pin_oe_n, .card_data_pin_in);
  scac_card_model u_scac_card_model (.card_pwr_en, .card_data_pin_out, .card_data_pin_oe_n, .card_pull_low,
    .card_data_pin_in);

  // Collects every timer expiry pulse seen since reset.
  always @(posedge core_clk) begin
    exp_seen <= rst ? 3'b000 : exp_seen | timer_expired;
  end

  // Clock at 40 MHz.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Prints the verdict and stops the run.
  task final_report;
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One cycle pulse of new data (1) or buffer read (0).
  task strobe(input logic s);
    @(posedge core_clk);
    if (s) rx_word_strobe <= 1'b1;
    else rx_buffer_read <= 1'b1;
    @(posedge core_clk);
    rx_word_strobe <= 1'b0;
    rx_buffer_read <= 1'b0;
  endtask

  // Counts clock edges up to the next time unit tick.
  task to_tick(output int g);
    g = 0;
    do begin
      @(posedge core_clk);
      g++;
    end while (etu_tick !== 1'b1 && g < 2000);
    if (g >= 2000) begin
      fail_count++;
      final_report;
    end
  endtask

  // Pulls the card line low, lets it go and counts the cycles in which the host drives it.
  task pin_pulse(output int c);
    c = 0;
    @(posedge core_clk);
    card_pull_low <= 1'b1;
    wt(5);
    card_pull_low <= 1'b0;
    repeat (8) begin
      @(posedge core_clk);
      c += (card_data_pin_oe_n === 1'b0);
    end
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, rx_word_strobe, rx_buffer_read, card_pull_low} = '0;
    paddr = '0;
    pwdata = '0;
    wt(5);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, adr[i], 32'h0);
      `CHK(rd, rst_v[i])
    end
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, adr[i], wr_v[i]);
      apb(1'b0, adr[i], 32'h0);
      `CHK(rd, rb_v[i])
    end
    `CHK(extra_guard_etus, 8'ha5)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK(err, 1'b1)
    // Engine off: starts and triggers are dropped, mode bits kept.
    apb(1'b1, SCAC_ADDR_ALTCTL, 32'h110fc);
    apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
    `CHK(rd, 32'h11000)
    `CHK(rx_guard_check_enable, 1'b1)
    // The time unit generator only runs with the engine on.
    apb(1'b1, SCAC_ADDR_CTRL, 32'h1);
    apb(1'b1, SCAC_ADDR_ETU, 32'h5);
    to_tick(gap_a);
    to_tick(gap_a);
    `CHK(gap_a, 6)
    apb(1'b1, SCAC_ADDR_ETU, 32'h8005);
    to_tick(gap_a);
    to_tick(gap_a);
    to_tick(gap_b);
    `CHK((gap_a > gap_b) ? gap_a - gap_b : gap_b - gap_a, 1)
    apb(1'b1, SCAC_ADDR_ETU, 32'h5);
    // Each sequence with its own step spacing; three steps of (42 << sel) + 1 clocks.
    apb(1'b1, SCAC_ADDR_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, SCAC_ADDR_ALTCTL, (32'h4 << k) | (k << 8));
      wt((126 << k) - 16);
      apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
      `CHK(rd[2 + k], 1'b1)
      wt(24);
      apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
      `CHK(rd, k << 8)
      apb(1'b0, SCAC_ADDR_STAT, 32'h0);
      `CHK(rd[0], 1'b1)
      apb(1'b1, SCAC_ADDR_STAT, 32'h1);
      apb(1'b0, SCAC_ADDR_STAT, 32'h0);
      `CHK(rd[0], 1'b0)
    end
    `CHK({card_pwr_en, card_clk_en, card_rst_out}, 3'b111)
    apb(1'b1, SCAC_ADDR_ALTCTL, 32'h308);
    wt(20);
    apb(1'b1, SCAC_ADDR_CTRL, 32'h0);
    apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
    `CHK(rd, 32'h300)
    `CHK({card_clk_en, card_rst_out}, 2'b00)
    wt(1100);
    apb(1'b0, SCAC_ADDR_STAT, 32'h0);
    `CHK(rd[0], 1'b0)
    // Quasi mode boosts the rising line for one cycle; open-drain mode never drives it.
    pin_pulse(gap_a);
    `CHK(gap_a, 1)
    apb(1'b1, SCAC_ADDR_ALTCTL, 32'h10000);
    pin_pulse(gap_a);
    `CHK(gap_a, 0)
    // One-shot timers, each of the three started in turn with select 11.
    apb(1'b1, SCAC_ADDR_CTRL, 32'h7);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, SCAC_ADDR_ALTCTL, 32'h20 << i);
      apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
      `CHK(rd[15:13], 3'(1 << i))
      `CHK(rd[7:5], 3'(1 << i))
      wt(120);
      apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
      `CHK(rd[15:5], 11'h0)
    end
    `CHK(exp_seen, 3'b111)
    apb(1'b1, SCAC_ADDR_CTRL, 32'hf);
    apb(1'b1, SCAC_ADDR_ALTCTL, 32'h20);
    wt(120);
    apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
    `CHK(rd[13], 1'b1)
    apb(1'b1, SCAC_ADDR_ALTCTL, 32'h3);
    wt(3);
    apb(1'b0, SCAC_ADDR_ALTCTL, 32'h0);
    `CHK(rd[13], 1'b0)
    `CHK(rd[1:0], 2'b00)
    // Receive time-out: 3.5 units of 6 clocks, then disabled by zero.
    apb(1'b1, SCAC_ADDR_CTRL, 32'h41);
    apb(1'b1, SCAC_ADDR_RTO, 32'h3);
    apb(1'b1, SCAC_ADDR_STAT, 32'h2);
    strobe(1'b1);
    wt(8);
    `CHK(rx_timeout_irq, 1'b0)
    wt(30);
    `CHK(rx_timeout_irq, 1'b1)
    strobe(1'b0);
    wt(2);
    `CHK(rx_timeout_irq, 1'b0)
    apb(1'b1, SCAC_ADDR_RTO, 32'h0);
    apb(1'b1, SCAC_ADDR_STAT, 32'h2);
    strobe(1'b1);
    wt(60);
    `CHK(rx_timeout_irq, 1'b0)
    final_report;
  end
endmodule
